/* File: rtl/cq_status_pkg.sv */
// Constants and carrier types for the completion status encoder.
// Assumes one core clock and a register bus that is APB with 32-bit data.
// Overview of operation
// - Successful command reports all-zero status field.
// - Several causes: our choice, lowest code wins.
// - No-retry hint set when retry would fail.
// - Timed recovery abort clears no-retry hint.
// - Zero type and code clears no-retry hint.
// - More flag set when error log holds more.
// - Status type sits in bits 27:25.
// - Status code sits in bits 24:17.
// - Type 0h carries generic outcomes.
// - Type 1h carries opcode specific outcomes.
// - Media and integrity errors use type 2h.
// - Types 3h-6h never sent; 7h implementation only.
// - Code ranges: common, I/O set, implementation.
// - Several codes apply: report the smallest.
// - Status field fills bits 31:17.
// - Phase bit 16 inverts each queue pass.
package cq_status_pkg;

	// Register byte offsets.
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] DEPTH_OFFSET = 8'h04;
	localparam logic [7:0] STATE_OFFSET = 8'h08;
	localparam logic [7:0] IRQ_STAT_OFFSET = 8'h0C;
	localparam logic [7:0] IRQ_MASK_OFFSET = 8'h10;
	localparam logic [7:0] LAST_OFFSET = 8'h14;

	// Field positions and reset values.
	localparam int CTRL_VENDOR_EN_BIT = 0;
	localparam int STATE_PHASE_BIT = 16;
	localparam logic CTRL_VENDOR_EN_RESET = 1'b0;
	localparam logic [15:0] DEPTH_RESET = 16'h0040;
	localparam logic PHASE_RESET = 1'b1;
	localparam int IRQ_FAIL_BIT = 0;
	localparam int IRQ_SUBST_BIT = 1;
	localparam int IRQ_WRAP_BIT = 2;
	localparam int IRQ_W = 3;

	// Status types.
	localparam logic [2:0] TYPE_GENERIC = 3'h0;
	localparam logic [2:0] TYPE_CMD_SPECIFIC = 3'h1;
	localparam logic [2:0] TYPE_MEDIA = 3'h2;
	localparam logic [2:0] TYPE_RSVD_LO = 3'h3;
	localparam logic [2:0] TYPE_RSVD_HI = 3'h6;
	localparam logic [2:0] TYPE_IMPL = 3'h7;

	// Status code ranges and the substitute code.
	localparam logic [7:0] CODE_COMMON_MAX = 8'h7F;
	localparam logic [7:0] CODE_IO_MIN = 8'h80;
	localparam logic [7:0] CODE_IO_MAX = 8'hBF;
	localparam logic [7:0] CODE_IMPL_MIN = 8'hC0;
	localparam logic [7:0] CODE_SUCCESS = 8'h00;
	localparam logic [7:0] CODE_INTERNAL_ERROR = 8'h06;

	// One failure cause offered by command processing.
	typedef struct packed {
		logic valid;
		logic no_retry;
		logic [2:0] status_type;
		logic [7:0] status_code;
	} cause_type;

	// Per-command facts that go with the causes.
	typedef struct packed {
		logic [15:0] cid;
		logic more_info;
		logic tler_abort;
		logic admin_cmd;
	} cmd_info_type;

	// Completion status field, bits 31:17.
	typedef struct packed {
		logic no_retry_hint;
		logic more;
		logic [1:0] rsvd;
		logic [2:0] status_type_field;
		logic [7:0] status_code_field;
	} completion_status_field_type;

	// Fourth completion doubleword.
	typedef struct packed {
		completion_status_field_type sf;
		logic phase;
		logic [15:0] cid;
	} dw3_type;

endpackage

/* File: rtl/status_pick.sv */
// Picks one failure cause out of several offered in the same cycle.
// Assumes the causes are already cleaned of illegal types; purely combinational.
`timescale 1ns/1ps
module status_pick #(
	parameter int N = 4
) (
	// Offered causes
	input wire cq_status_pkg::cause_type cause [N],
	// Selection
	output logic found,
	output cq_status_pkg::cause_type best
);

	always_comb begin
		found = 1'b0;
		best = '0;
		for (int i = 0; i < N; i++) begin
			if (cause[i].valid) begin
				// Smallest code wins; equal codes fall back to the smaller type.
				if (!found || cause[i].status_code < best.status_code) begin
					best = cause[i];
				end else if (cause[i].status_code == best.status_code &&
					cause[i].status_type < best.status_type) begin
					best = cause[i];
				end
				found = 1'b1;
			end
		end
	end

endmodule

/* File: rtl/completion_status_encoder.sv */
// Builds the fourth completion doubleword: status field, phase tag and command id.
// Assumes command processing offers causes on the core clock and that a
// downstream queue writer takes entries with a valid/ready handshake.
// The interrupt is a level that software clears through the event register.
`timescale 1ns/1ps
module completion_status_encoder #(
	parameter int N = 4
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Completion request from command processing
	input wire logic cmp_valid,
	output logic cmp_ready,
	input wire cq_status_pkg::cmd_info_type cmp_info,
	input wire cq_status_pkg::cause_type cmp_cause [N],
	// Completion entry to the queue writer
	output logic entry_valid,
	input wire logic entry_ready,
	output cq_status_pkg::dw3_type entry_dw3,
	// Interrupt
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////////

	// Register map, one aligned 32-bit word each, unused bits read as zero.
	// CTRL: its lowest bit lets implementation-defined statuses through.
	// DEPTH: entries per queue pass; a write restarts the pass.
	// STATE: read only, the phase tag above the next slot number.
	// IRQ_STAT: sticky events, writing a one clears the bit.
	// IRQ_MASK: same layout as IRQ_STAT, a one lets the event reach irq.
	// LAST: read only, the last entry word handed to the queue writer.
	// Events: a failure was posted, a cause was replaced, the queue wrapped.
	// Unmapped addresses answer with an error, read as zero and ignore writes.

	typedef struct packed {
		// Holding stage towards the queue writer.
		logic ent_valid;
		cq_status_pkg::dw3_type ent;
		// Position in the current queue pass.
		logic phase;
		logic [15:0] slot;
		// Software-visible registers.
		logic vendor_en;
		logic [15:0] depth;
		logic [cq_status_pkg::IRQ_W-1:0] irq_stat;
		logic [cq_status_pkg::IRQ_W-1:0] irq_mask;
		// Read word and error captured in the setup cycle.
		logic [31:0] rdata;
		logic slverr;
	} state_type;

	state_type state_reg;
	state_type state_next;

	cq_status_pkg::cause_type clean [N];
	logic [N-1:0] subst;
	logic found;
	cq_status_pkg::cause_type best;
	logic last_slot;

	////////////////////////////////////////////////////////////////////////////////
	// Cause cleaning: anything that may not be sent becomes an internal error.
	// Each cause is checked on its own, so the pick below sees only legal ones.

	always_comb begin
		for (int i = 0; i < N; i++) begin
			clean[i] = cmp_cause[i];
			subst[i] = 1'b0;
			if (cmp_cause[i].valid) begin
				// Reserved types are never put on the wire.
				if (cmp_cause[i].status_type >= cq_status_pkg::TYPE_RSVD_LO &&
					cmp_cause[i].status_type <= cq_status_pkg::TYPE_RSVD_HI) begin
					subst[i] = 1'b1;
				end
				// Implementation statuses only when software allows them.
				if (!state_reg.vendor_en &&
					(cmp_cause[i].status_type == cq_status_pkg::TYPE_IMPL ||
					cmp_cause[i].status_code >= cq_status_pkg::CODE_IMPL_MIN)) begin
					subst[i] = 1'b1;
				end
				// I/O command set codes make no sense for an admin command.
				if (cmp_info.admin_cmd &&
					cmp_cause[i].status_code >= cq_status_pkg::CODE_IO_MIN &&
					cmp_cause[i].status_code <= cq_status_pkg::CODE_IO_MAX) begin
					subst[i] = 1'b1;
				end
				// A cause posing as success carries no error and is dropped.
				if (cmp_cause[i].status_type == cq_status_pkg::TYPE_GENERIC &&
					cmp_cause[i].status_code == cq_status_pkg::CODE_SUCCESS) begin
					clean[i].valid = 1'b0;
				end
			end
			// The replacement clears the hint: once software allows the status,
			// or fixes the command, a retry may well succeed.
			if (subst[i]) begin
				clean[i].valid = 1'b1;
				clean[i].no_retry = 1'b0;
				clean[i].status_type = cq_status_pkg::TYPE_GENERIC;
				clean[i].status_code = cq_status_pkg::CODE_INTERNAL_ERROR;
			end
		end
	end

	// Smallest code wins; a tie goes to the smaller type.
	status_pick #(
		.N(N)
	) pick (
		.cause(clean),
		.found(found),
		.best(best)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Queue position: is the slot being filled the last one of this pass?
	// A depth of zero would never wrap, so it behaves as a queue of one entry.

	always_comb begin
		last_slot = 1'b0;
		if (state_reg.depth == 16'h0000) begin
			last_slot = 1'b1;
		end else if (state_reg.slot >= state_reg.depth - 16'h0001) begin
			last_slot = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state.

	always_comb begin
		cq_status_pkg::dw3_type dw;
		logic take;
		logic wrap;
		logic apb_wr;
		logic [cq_status_pkg::IRQ_W-1:0] ev;
		dw = '0;
		take = 1'b0;
		wrap = 1'b0;
		apb_wr = 1'b0;
		ev = '0;
		state_next = state_reg;

		// Output stage: an accepted entry frees the slot.
		// The slot is freed even while a new entry is written into it below.
		if (state_reg.ent_valid && entry_ready) begin
			state_next.ent_valid = 1'b0;
		end
		// A completion is taken only while the holding stage is free or drains now.
		take = cmp_valid && cmp_ready;

		// Status field assembly; the struct order fixes the bit layout.
		// The command id travels unchanged so that software can match the entry.
		dw.cid = cmp_info.cid;
		dw.phase = state_reg.phase;
		dw.sf.rsvd = 2'b00;
		if (found) begin
			dw.sf.status_type_field = best.status_type;
			dw.sf.status_code_field = best.status_code;
			dw.sf.more = cmp_info.more_info;
			dw.sf.no_retry_hint = best.no_retry;
			if (cmp_info.tler_abort) begin
				dw.sf.no_retry_hint = 1'b0;
			end
			// Success causes are dropped during cleaning, so this guard only
			// matters should that filter ever be relaxed.
			if (best.status_type == cq_status_pkg::TYPE_GENERIC &&
				best.status_code == cq_status_pkg::CODE_SUCCESS) begin
				dw.sf.no_retry_hint = 1'b0;
			end
		end else begin
			// No failure: the whole field reads zero, the more flag included.
			dw.sf = '0;
		end

		if (take) begin
			state_next.ent_valid = 1'b1;
			state_next.ent = dw;
			wrap = last_slot;
			if (wrap) begin
				state_next.slot = '0;
				state_next.phase = ~state_reg.phase;
			end else begin
				state_next.slot = state_reg.slot + 16'h0001;
			end
			// One accepted completion may raise several events at once.
			ev[cq_status_pkg::IRQ_FAIL_BIT] = found;
			ev[cq_status_pkg::IRQ_SUBST_BIT] = |subst;
			ev[cq_status_pkg::IRQ_WRAP_BIT] = wrap;
		end

		// APB setup cycle: latch read data and error for the access phase.
		// Capturing the word here keeps prdata a flop output with no wait state.
		if (psel && !penable) begin
			state_next.slverr = 1'b0;
			case (paddr)
				cq_status_pkg::CTRL_OFFSET: begin
					state_next.rdata = '0;
					state_next.rdata[cq_status_pkg::CTRL_VENDOR_EN_BIT] = state_reg.vendor_en;
				end
				cq_status_pkg::DEPTH_OFFSET: begin
					state_next.rdata = {16'h0000, state_reg.depth};
				end
				cq_status_pkg::STATE_OFFSET: begin
					state_next.rdata = {15'h0000, state_reg.phase, state_reg.slot};
				end
				cq_status_pkg::IRQ_STAT_OFFSET: begin
					state_next.rdata = {29'h0, state_reg.irq_stat};
				end
				cq_status_pkg::IRQ_MASK_OFFSET: begin
					state_next.rdata = {29'h0, state_reg.irq_mask};
				end
				cq_status_pkg::LAST_OFFSET: begin
					state_next.rdata = state_reg.ent;
				end
				default: begin
					state_next.rdata = '0;
					state_next.slverr = 1'b1;
				end
			endcase
		end

		// APB access phase: writes take effect on the completing edge.
		apb_wr = psel && penable && pwrite;
		if (apb_wr) begin
			case (paddr)
				cq_status_pkg::CTRL_OFFSET: begin
					state_next.vendor_en = pwdata[cq_status_pkg::CTRL_VENDOR_EN_BIT];
				end
				cq_status_pkg::DEPTH_OFFSET: begin
					// A new depth restarts the queue pass. It also wins over a completion
					// taken in the same cycle, whose entry keeps the old phase tag.
					state_next.depth = pwdata[15:0];
					state_next.slot = '0;
					state_next.phase = cq_status_pkg::PHASE_RESET;
				end
				cq_status_pkg::IRQ_STAT_OFFSET: begin
					// Ones clear the matching sticky bits; zeros leave them alone.
					state_next.irq_stat = state_reg.irq_stat &
						~pwdata[cq_status_pkg::IRQ_W-1:0];
				end
				cq_status_pkg::IRQ_MASK_OFFSET: begin
					state_next.irq_mask = pwdata[cq_status_pkg::IRQ_W-1:0];
				end
				default: begin
					// Read-only and unmapped addresses ignore the write.
				end
			endcase
		end

		// New events are applied last so a set beats a clear in the same cycle.
		state_next.irq_stat = state_next.irq_stat | ev;
	end

	////////////////////////////////////////////////////////////////////////////////

	// All state sits in one register; the reset values mirror the register map.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// The phase tag starts at one so that software, which zeroes the queue,
			// sees every entry of the first pass as new.
			state_reg <= '{
				ent_valid: 1'b0,
				ent: '0,
				phase: cq_status_pkg::PHASE_RESET,
				slot: '0,
				vendor_en: cq_status_pkg::CTRL_VENDOR_EN_RESET,
				depth: cq_status_pkg::DEPTH_RESET,
				irq_stat: '0,
				irq_mask: '0,
				rdata: '0,
				slverr: 1'b0
			};
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.

	// Zero wait states: the read word was captured in the setup cycle.
	assign pready = psel && penable;
	assign prdata = state_reg.rdata;
	assign pslverr = psel && penable && state_reg.slverr;

	// A single holding stage; a stalled writer stalls command processing.
	assign cmp_ready = !state_reg.ent_valid || entry_ready;
	assign entry_valid = state_reg.ent_valid;
	assign entry_dw3 = state_reg.ent;

	// A level output: it falls once every pending event is cleared or masked.
	assign irq = |(state_reg.irq_stat & state_reg.irq_mask);

endmodule

/* File: dv/cq_host_model.sv */
// Queue writer model that takes completion entries like host memory would.
// Assumes one core clock; slow makes it accept only on alternate cycles.
`timescale 1ns/1ps
module cq_host_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Entry stream
	input wire logic entry_valid,
	input wire cq_status_pkg::dw3_type entry_dw3,
	output logic entry_ready,
	// Bench side
	input wire logic slow,
	output cq_status_pkg::dw3_type got,
	output int cnt
);
////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			entry_ready <= 1'b0;
			got <= '0;
			cnt <= 0;
		end else begin
			entry_ready <= slow ? !entry_ready : 1'b1;
			if (entry_valid && entry_ready) begin
				got <= entry_dw3;
				cnt <= cnt + 1;
			end
		end
	end
endmodule

/* File: dv/cq_status_chk.sv */
// Concurrent checks on the completion status encoder ports.
// Assumes a single core clock and an active low asynchronous reset.
`timescale 1ns/1ps
module cq_status_chk #(
	parameter int N = 4
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	// Completion path
	input wire logic cmp_valid,
	input wire logic cmp_ready,
	input wire cq_status_pkg::cmd_info_type cmp_info,
	input wire logic entry_valid,
	input wire logic entry_ready,
	input wire cq_status_pkg::dw3_type entry_dw3
);
////////////////////////////////////////
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence take_s;
		cmp_valid && cmp_ready;
	endsequence
	sequence wait_s;
		entry_valid && !entry_ready;
	endsequence
	rsvd_zero_a: assert property (entry_valid |-> entry_dw3.sf.rsvd == 2'h0)
		else $error("reserved bits set");
	type_legal_a: assert property (entry_valid |-> entry_dw3.sf.status_type_field < 3'h3
		|| entry_dw3.sf.status_type_field == 3'h7) else $error("reserved type sent");
	zero_hint_a: assert property (entry_valid && entry_dw3.sf[10:0] == 11'h0
		|-> entry_dw3.sf == 15'h0) else $error("nonzero flags on success");
	answer_a: assert property (take_s |=> entry_valid && entry_dw3.cid == $past(cmp_info.cid))
		else $error("entry missing a cycle after take");
	hold_a: assert property (wait_s |=> entry_valid && $stable(entry_dw3))
		else $error("entry changed while waiting");
	tler_a: assert property (take_s ##0 cmp_info.tler_abort |=> !entry_dw3.sf.no_retry_hint)
		else $error("hint set on timed abort");
	more_a: assert property (take_s ##0 !cmp_info.more_info |=> !entry_dw3.sf.more)
		else $error("more flag without log");
	pready_a: assert property (psel && penable |-> pready) else $error("bus wait state");
	stall_a: assert property (!cmp_ready |-> wait_s) else $error("request refused without cause");
endmodule
bind completion_status_encoder cq_status_chk #(.N(N)) u_cq_status_chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .cmp_valid(cmp_valid),
	.cmp_ready(cmp_ready), .cmp_info(cmp_info), .entry_valid(entry_valid),
	.entry_ready(entry_ready), .entry_dw3(entry_dw3));

/* File: dv/tb.sv */
// Self-checking bench for the completion status encoder.
// Assumes the host model and the bound checker are compiled before it.
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic cmp_valid = 1'b0, slow = 1'b0, ph = 1'b1, er, pready, pslverr, cmp_ready;
	logic entry_valid, entry_ready, irq;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	cq_status_pkg::cmd_info_type info = '0;
	cq_status_pkg::cause_type cs [4] = '{default: '0};
	cq_status_pkg::dw3_type dw3, got;
	int cnt, err_total = 0, checked = 0, n = 0;
	completion_status_encoder #(.N(4)) u_completion_status_encoder (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cmp_valid(cmp_valid), .cmp_ready(cmp_ready), .cmp_info(info), .cmp_cause(cs),
		.entry_valid(entry_valid), .entry_ready(entry_ready), .entry_dw3(dw3), .irq(irq));
	cq_host_model u_cq_host_model (.pclk(pclk), .presetn(presetn), .entry_valid(entry_valid),
		.entry_dw3(dw3), .entry_ready(entry_ready), .slow(slow), .got(got), .cnt(cnt));
////////////////////////////////////////
	initial begin
		forever #5 pclk = ~pclk;
	end
	task automatic end_of_test;
		if (err_total == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Cause and expectation words: bit 15 valid, bit 12 hint, 10:8 type, 7:0 code.
	function automatic logic [12:0] k(input logic [15:0] v);
		return {v[15], v[12], v[10:8], v[7:0]};
	endfunction
	task automatic run(input logic [2:0] f, input logic [15:0] a, b, c, e);
		@(posedge pclk);
		n++;
		info <= {n[15:0], f};
		cs <= '{k(a), k(b), k(c), 13'h0};
		cmp_valid <= 1'b1;
		do @(posedge pclk); while (cmp_ready !== 1'b1);
		cmp_valid <= 1'b0;
		repeat (8) if (cnt < n) @(posedge pclk);
		`CHK(got, {e[12], f[2], 2'b00, e[10:0], ph, n[15:0]})
		if (n % 2 == 0)
			ph = ~ph;
	endtask
////////////////////////////////////////
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h04, 32'h0);
		`CHK(rd, 32'h40)
		apb(1'b0, 8'h08, 32'h0);
		`CHK(rd, 32'h10000)
		apb(1'b1, 8'h18, 32'h5);
		apb(1'b0, 8'h18, 32'h0);
		`CHK({er, rd}, {1'b1, 32'h0})
		apb(1'b1, 8'h04, 32'h2);
		run(3'h0, 16'h0, 16'h0, 16'h0, 16'h0);
		run(3'h0, 16'h9000, 16'h0, 16'h0, 16'h0);
		slow <= 1'b1;
		run(3'h4, 16'h9005, 16'h9102, 16'h8281, 16'h1102);
		run(3'h0, 16'h8204, 16'h8004, 16'h0, 16'h0004);
		run(3'h2, 16'h9210, 16'h0, 16'h0, 16'h0210);
		run(3'h0, 16'h9301, 16'h0, 16'h0, 16'h0006);
		run(3'h0, 16'h97C5, 16'h0, 16'h0, 16'h0006);
		run(3'h1, 16'h8085, 16'h0, 16'h0, 16'h0006);
		slow <= 1'b0;
		apb(1'b1, 8'h00, 32'h1);
		run(3'h0, 16'h97C5, 16'h0, 16'h0, 16'h17C5);
		run(3'h0, 16'h8185, 16'h0, 16'h0, 16'h0185);
		apb(1'b0, 8'h0C, 32'h0);
		`CHK({irq, rd}, {1'b0, 32'h7})
		apb(1'b1, 8'h10, 32'h2);
		apb(1'b0, 8'h10, 32'h0);
		`CHK({irq, rd}, {1'b1, 32'h2})
		apb(1'b1, 8'h0C, 32'h2);
		apb(1'b0, 8'h0C, 32'h0);
		`CHK({irq, rd}, {1'b0, 32'h5})
		apb(1'b0, 8'h08, 32'h0);
		`CHK(rd, 32'h0)
		end_of_test();
	end
	initial begin
		#100000;
		err_total++;
		end_of_test();
	end
endmodule
